// ===== design/sw_timer_pkg.sv
// constants shared by the stopwatch timer block and its core
`default_nettype none
package sw_timer_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PRIO = 16'hff20;
  localparam logic [15:0] IDX_EN = 16'hff22;
  localparam logic [15:0] IDX_FLAG = 16'hff24;
  localparam logic [15:0] IDX_CTRL = 16'hff42;
  localparam logic [15:0] IDX_COUNT = 16'hff43;
  localparam int unsigned APB_AW = 18;
  localparam logic [17:0] ADDR_PRIO = {IDX_PRIO, 2'b00};
  localparam logic [17:0] ADDR_EN = {IDX_EN, 2'b00};
  localparam logic [17:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
  localparam logic [17:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [17:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned CLR_BIT = 1;
  localparam int unsigned LVL_LSB = 2;
  localparam int unsigned EV_LSB = 4;
  // ----------------------------------------------------------------
  // reset values, counting constants, exception vectors
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [8:0] ACC_STEP = 9'h064;
  localparam logic [23:0] VEC_100HZ = 24'h00_0016;
  localparam logic [23:0] VEC_10HZ = 24'h00_0018;
  localparam logic [23:0] VEC_1HZ = 24'h00_001a;

  // one bcd step: returns {wrap, next digit}
  function automatic logic [4:0] bcd_inc(input logic [3:0] d);
    if (d >= DIGIT_MAX) begin
      return {1'b1, 4'h0};
    end
    return {1'b0, 4'(d + 4'h1)};
  endfunction
endpackage
`default_nettype wire

// ===== design/sw_core_if.sv
// signals between the register side and the bcd counting core
`default_nettype none
interface sw_core_if;
  logic tick_fall;
  logic run_req;
  logic clear;
  logic running;
  logic [3:0] hund;
  logic [3:0] tenth;
  logic ev100;
  logic ev10;
  logic ev1;
  modport core (
    input tick_fall, run_req, clear,
    output running, hund, tenth, ev100, ev10, ev1
  );
  modport ctl (
    output tick_fall, run_req, clear,
    input running, hund, tenth, ev100, ev10, ev1
  );
endinterface
`default_nettype wire

// ===== design/sw_bcd_core.sv
// feedback divider and two cascaded bcd digits of the stopwatch
`default_nettype none
module sw_bcd_core
  import sw_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sw_core_if.core sw
);
  typedef struct packed {
    logic [7:0] acc;
    logic [3:0] hund;
    logic [3:0] tenth;
    logic running;
    logic ev100;
    logic ev10;
    logic ev1;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;
  logic [8:0] sum;
  logic [4:0] h_step;
  logic [4:0] t_step;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ev100 = 1'b0;
    next_s.ev10 = 1'b0;
    next_s.ev1 = 1'b0;
    sum = {1'b0, s.acc} + ACC_STEP;
    h_step = bcd_inc(s.hund);
    t_step = bcd_inc(s.tenth);
    if (sw.tick_fall) begin
      next_s.running = sw.run_req;
      if (s.running) begin // old state counts once more on a stop
        next_s.acc = sum[7:0]; // 100 carries per 256 ticks
        if (sum[8]) begin
          next_s.ev100 = 1'b1;
          next_s.hund = h_step[3:0];
          if (h_step[4]) begin
            next_s.ev10 = 1'b1;
            next_s.tenth = t_step[3:0];
            next_s.ev1 = t_step[4];
          end
        end
      end
    end
    if (sw.clear) begin // run state untouched
      next_s.acc = 8'h00;
      next_s.hund = 4'h0;
      next_s.tenth = 4'h0;
      next_s.ev100 = 1'b0;
      next_s.ev10 = 1'b0;
      next_s.ev1 = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sw.running = s.running;
  assign sw.hund = s.hund;
  assign sw.tenth = s.tenth;
  assign sw.ev100 = s.ev100;
  assign sw.ev10 = s.ev10;
  assign sw.ev1 = s.ev1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_digits_bcd: assert property (s.hund <= DIGIT_MAX && s.tenth <= DIGIT_MAX)
    else $error("bcd digit out of range");
  a_stop_hold: assert property ((!s.running && !sw.clear) |=> $stable({s.hund, s.tenth}))
    else $error("count moved while stopped");
  a_run_sync: assert property ($changed(s.running) |-> $past(sw.tick_fall))
    else $error("run state changed off a tick edge");
  a_carry_cascade: assert property ((s.ev1 |-> s.ev10) and (s.ev10 |-> s.ev100 && s.hund == 4'h0))
    else $error("carry chain broken");
  a_divider_gap: assert property (s.ev100 |=> !s.ev100)
    else $error("100 hz events back to back");
endmodule // sw_bcd_core
`default_nettype wire

// ===== design/sw_timer.sv
// stopwatch timer: apb register file, interrupt flags and request
// Behaviour
// - vectors 000016h, 000018h, 00001ah per source
// - count: hundredths low nibble, tenths high
// - count register is read-only
// - reset clears both count digits
// - write one to clear strobe clears count
// - clear while running keeps counting from zero
// - run bit starts, stops, holds count
// - reset leaves stopwatch stopped
// - level field bits 3:2, zero means none
// - reset sets level field to zero
// - enables at bits 4,5,6, reset zero
// - flags set on 1, 10, 100 hz edges
// - flags set regardless of enable or level
// - request needs flag, enable, level above mask
// - flags clear on write one, reset zero
// - run change acts on next tick edge
// - run reads one until really stopped
// - two cascaded bcd digits from 256 hz
// - divider gives 2 or 3 tick intervals
// - tenths carry at 25 or 26 ticks
`default_nettype none
module sw_timer
  import sw_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc_clock,
  input wire logic cpu_mask_lo,
  input wire logic cpu_mask_hi,
  output logic irq_req,
  output logic [1:0] irq_level,
  output logic [23:0] irq_vector
);
  typedef struct packed {
    logic tick_q;
    logic run_req;
    logic clear;
    logic [1:0] prio;
    logic [2:0] en;
    logic [2:0] flags;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic irq;
    logic [1:0] level;
    logic [23:0] vector;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  sw_core_if sw ();

  logic access;
  logic done;
  logic wr;
  logic [2:0] pend;
  logic [1:0] mask;
  logic [7:0] wbyte;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return a == ADDR_PRIO || a == ADDR_EN || a == ADDR_FLAG
        || a == ADDR_CTRL || a == ADDR_COUNT;
  endfunction

  function automatic logic [7:0] read_byte(input logic [APB_AW-1:0] a, input top_state_t st,
                                           input logic run_rd, input logic [7:0] cnt);
    logic [7:0] v;
    v = RST_BYTE;
    unique case (a)
      ADDR_PRIO: v[LVL_LSB +: 2] = st.prio;
      ADDR_EN: v[EV_LSB +: 3] = st.en;
      ADDR_FLAG: v[EV_LSB +: 3] = st.flags;
      ADDR_CTRL: v[RUN_BIT] = run_rd; // strobe reads zero
      ADDR_COUNT: v = cnt;
      default: v = RST_BYTE;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // core hookup
  // ----------------------------------------------------------------
  assign sw.tick_fall = s.tick_q & ~low_speed_osc_clock;
  assign sw.run_req = s.run_req;
  assign sw.clear = s.clear;

  sw_bcd_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .sw(sw.core)
  );

  // ----------------------------------------------------------------
  // bus, registers, flags and request
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    access = psel & penable;
    done = access & s.ready;
    wr = done & pwrite;
    wbyte = pwdata[7:0];
    mask = {cpu_mask_hi, cpu_mask_lo};
    next_s.tick_q = low_speed_osc_clock;
    next_s.clear = 1'b0;
    next_s.ready = access & ~s.ready;
    next_s.slverr = 1'b0;
    next_s.rdata = 32'h0000_0000;
    if (access && !s.ready) begin
      next_s.slverr = ~is_mapped(paddr);
      if (!pwrite) begin
        // run reads one until the core has stopped
        next_s.rdata = {24'h00_0000,
                        read_byte(paddr, s, s.run_req | sw.running, {sw.tenth, sw.hund})};
      end
    end
    if (wr) begin
      unique case (paddr)
        ADDR_PRIO: next_s.prio = wbyte[LVL_LSB +: 2];
        ADDR_EN: next_s.en = wbyte[EV_LSB +: 3];
        ADDR_FLAG: next_s.flags = s.flags & ~wbyte[EV_LSB +: 3];
        ADDR_CTRL: begin
          next_s.run_req = wbyte[RUN_BIT];
          next_s.clear = wbyte[CLR_BIT];
        end
        default: next_s.prio = s.prio; // count and unmapped ignore writes
      endcase
    end
    // set wins over a same-cycle clear, independent of enable and level
    next_s.flags = next_s.flags | {sw.ev100, sw.ev10, sw.ev1};
    pend = s.flags & s.en;
    next_s.irq = (|pend) && (s.prio > mask);
    next_s.level = s.prio;
    if (pend[2]) begin
      next_s.vector = VEC_100HZ;
    end else if (pend[1]) begin
      next_s.vector = VEC_10HZ;
    end else if (pend[0]) begin
      next_s.vector = VEC_1HZ;
    end else begin
      next_s.vector = 24'h00_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign irq_req = s.irq;
  assign irq_level = s.level;
  assign irq_vector = s.vector;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clear_zero: assert property (s.clear |=> sw.hund == 4'h0 && sw.tenth == 4'h0)
    else $error("clear strobe did not zero count");
  a_run_read: assert property ((access && !s.ready && !pwrite && paddr == ADDR_CTRL
                                && sw.running) |=> s.rdata[RUN_BIT])
    else $error("run bit read zero while still running");
  a_strobe_read: assert property ((access && !s.ready && !pwrite && paddr == ADDR_CTRL)
                                  |=> s.rdata[7:1] == 7'h00)
    else $error("control unused or strobe bits read nonzero");
  a_flag_set: assert property (sw.ev100 |=> s.flags[2])
    else $error("100 hz flag not set");
  a_flag_w1c: assert property ((wr && paddr == ADDR_FLAG && pwdata[EV_LSB] && !sw.ev1)
                               |=> !s.flags[0])
    else $error("1 hz flag not cleared by write one");
  a_irq_gate: assert property (s.irq |-> ($past(s.prio) > $past(mask))
                               && $past(|(s.flags & s.en)))
    else $error("request without enabled flag above mask");
  a_vector_pick: assert property ((s.flags[2] && s.en[2]) |=> s.vector == VEC_100HZ)
    else $error("wrong vector for 100 hz source");
  a_pready_pulse: assert property (s.ready |=> !s.ready)
    else $error("pready held past one cycle");

  c_irq_raised: cover property (s.irq && s.vector == VEC_1HZ);
  c_clear_running: cover property (s.clear && sw.running);
  c_stop_pending: cover property (!s.run_req && sw.running ##1 sw.tick_fall);
  c_flag_race: cover property (wr && paddr == ADDR_FLAG && sw.ev100);
endmodule // sw_timer
`default_nettype wire

// ===== tb/sw_cpu_model.sv
// cpu-side model: apb master, interrupt mask lines and low-speed tick source
`default_nettype none
module sw_cpu_model
  import sw_timer_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  output logic osc,
  output logic [1:0] mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] exp_q[$];
  // idle bus: strobes low, the rest random until the first transfer
  initial begin
    {psel, penable} = 2'b00;
    pwrite = 1'($random(sw_timer_bench.seed));
    paddr = APB_AW'($random(sw_timer_bench.seed));
    pwdata = $random(sw_timer_bench.seed);
    osc = 1'b1;
    mask = 2'($random(sw_timer_bench.seed));
  end
  // one transfer; e is {pslverr, read byte} expected with the answer
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [7:0] d,
                      input logic [8:0] e);
    int k;
    k = 0;
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    // released lines show the inverse, never a stale value
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~{24'h00_0000, d};
    if (k >= 20) begin
      sw_timer_bench.n_fail++;
      sw_timer_bench.stop_test();
    end
  endtask
  // n falling edges per call, 8 clocks apart; the source runs on, no sleep is modelled
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      osc <= 1'b0;
      repeat (4) @(posedge pclk);
      osc <= 1'b1;
    end
  endtask
  // software lowers or raises its own mask level
  task automatic set_mask(input logic [1:0] m);
    @(posedge pclk);
    mask <= m;
  endtask
endmodule // sw_cpu_model
`default_nettype wire

// ===== tb/sw_timer_bench.sv
// self-checking bench of the stopwatch timer
`default_nettype none
module sw_timer_bench
  import sw_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, osc, irq_req, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] mask, irq_level;
  logic [23:0] irq_vector;
  logic [23:0] vec [3] = '{VEC_10HZ, VEC_1HZ, 24'h00_0000};
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h648d_cc5a;
  int tot = 0;
  int t;
  initial begin
    forever #4 pclk = ~pclk;
  end
  sw_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_osc_clock(osc), .cpu_mask_lo(mask[0]),
    .cpu_mask_hi(mask[1]), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector));
  sw_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .osc(osc), .mask(mask));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [7:0] e);
    cpu.xfer(1'b0, a, 8'($random(seed)), {1'b0, e});
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, 9'h000);
  endtask
  // count byte after k ticks from a clear: hundredths = 100k/256
  function automatic logic [7:0] cnt_byte(input int k);
    int h;
    h = (100 * k) / 256;
    return {4'((h / 10) % 10), 4'(h % 10)};
  endfunction
  task automatic run_for(input int k);
    wr(ADDR_CTRL, 8'h01);
    cpu.tick(k + 1);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h01);
    cpu.tick(1);
    tot += k + 1;
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_COUNT, cnt_byte(tot));
  endtask
  // ----------------------------------------------------------------
  // answer monitor
  // ----------------------------------------------------------------
  initial begin : mon
    logic [8:0] e;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        e = (cpu.exp_q.size() > 0) ? cpu.exp_q.pop_front() : 9'h1ff;
        chk({pslverr, prdata}, {e[8], 24'h00_0000, e[7:0]});
      end
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_PRIO, RST_BYTE);
    rd(ADDR_EN, RST_BYTE);
    rd(ADDR_FLAG, RST_BYTE);
    rd(ADDR_CTRL, RST_BYTE);
    rd(ADDR_COUNT, RST_BYTE);
    cpu.xfer(1'b0, 18'h0_0010, 8'h00, 9'h100);
    $display("test 1 done");
    wr(ADDR_PRIO, 8'hff);
    rd(ADDR_PRIO, 8'h0c);
    chk({31'h0, irq_level}, 33'h3);
    wr(ADDR_EN, 8'hff);
    rd(ADDR_EN, 8'h70);
    wr(ADDR_EN, 8'h00);
    wr(ADDR_COUNT, 8'h55);
    rd(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'hfe);
    rd(ADDR_CTRL, 8'h00);
    $display("test 2 done");
    t = 1 + ($unsigned($random(seed)) % 60);
    run_for(t);
    cpu.tick(5);
    rd(ADDR_COUNT, cnt_byte(tot));
    run_for(30);
    rd(ADDR_FLAG, 8'h60);
    wr(ADDR_FLAG, 8'h20);
    rd(ADDR_FLAG, 8'h40);
    wr(ADDR_FLAG, 8'h00);
    rd(ADDR_FLAG, 8'h40);
    $display("test 3 done");
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    cpu.tick(11);
    wr(ADDR_CTRL, 8'h03);
    cpu.tick(20);
    rd(ADDR_COUNT, cnt_byte(20));
    cpu.tick(236);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_FLAG, 8'h70);
    wr(ADDR_CTRL, 8'h00);
    cpu.tick(1);
    $display("test 4 done");
    wr(ADDR_PRIO, 8'h08);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq_req}, 33'h0);
    wr(ADDR_EN, 8'h70);
    for (int m = 0; m < 4; m++) begin
      cpu.set_mask(2'(m));
      repeat (3) @(posedge pclk);
      chk({32'h0, irq_req}, {32'h0, m < 2});
    end
    cpu.set_mask(2'b00);
    repeat (3) @(posedge pclk);
    chk({8'h00, irq_req, irq_vector}, {8'h00, 1'b1, VEC_100HZ});
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_FLAG, 8'h40 >> i);
      repeat (3) @(posedge pclk);
      chk({8'h00, irq_req, irq_vector}, {8'h00, i < 2, vec[i]});
    end
    $display("test 5 done");
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule // sw_timer_bench
`default_nettype wire
